// file: cdp_clock_power.sv
// Clock divide, multiplier, regulator and power-mode sequencing
// Function
// (R1) Deep sleep stops core and system clocks; only the reset event exits.
// (R2) Deep sleep blocks asynchronous peripherals from internal resources and memory.
// (R3) Leaving deep sleep enters full-on if bypass clear, active if set.
// (R4) Regulator field write of 00 stops clocks, removes core supply, enters hibernate.
// (R5) Hibernate three-states all external pins unless individually excepted.
// (R6) Reset in hibernate restarts the regulator, then starts boot.
// (R7) Core voltage set in 50 mV steps from 0.85 V to 1.30 V.
// (R8) Multiplier 0.5x to 64x, 10x after reset, software changeable.
// (R9) System divide field divides PLL output by its value, 1 to 15.
// (R10) System divide changes take effect immediately, no lock wait.
// (R11) Core divide field selects ratio 1, 2, 4 or 8.
// (R12) Lock wait count resets to 0x200.
// (R13) Lock wait counter counts input-clock periods.
// (R14) Software programs lock count for 40 us single, 80 us combined changes.
// (R15) Wakeup from sleep samples bypass selection to choose next state.
// (R16) Multiplier or voltage change holds clocks off until lock count expires; code locks on full-on changes, active voltage changes, active bypass clear.
`default_nettype none

module cdp_clock_power (
	input  wire logic                          clock_in,
	input  wire logic                          rst_b_in,
	input  wire logic                          reset_event_b_in,
	input  wire logic                          wakeup_in,
	input  wire logic                          bypass_in,
	input  wire logic                          sleep_req_in,
	input  wire logic                          deep_sleep_req_in,
	input  wire logic                          multiplier_write_in,
	input  wire logic [cdp_pkg::MULT_W-1:0]    multiplier_select_in,
	input  wire logic                          divide_write_in,
	input  wire logic [cdp_pkg::SDIV_W-1:0]    system_divide_select_in,
	input  wire logic [cdp_pkg::CDIV_W-1:0]    core_divide_select_in,
	input  wire logic                          regulator_write_in,
	input  wire logic [cdp_pkg::REGULATOR_FIELD_A_W-1:0]    regulator_field_a_in,
	input  wire logic [cdp_pkg::VSEL_W-1:0]    voltage_select_in,
	input  wire logic                          lock_count_write_in,
	input  wire logic [cdp_pkg::LOCK_W-1:0]    lock_wait_count_in,
	output var  logic                          core_clock_en_out,
	output var  logic                          system_clock_en_out,
	output var  cdp_pkg::cdp_mode_t            mode_out,
	output var  logic                          async_access_block_out,
	output var  logic                          pin_tristate_out,
	output var  logic                          regulator_on_out,
	output var  logic [cdp_pkg::MV_W-1:0]      core_voltage_mv_out,
	output var  logic [cdp_pkg::MULT_W-1:0]    multiplier_out,
	output var  logic [cdp_pkg::SDIV_W-1:0]    system_divide_select_out,
	output var  logic [cdp_pkg::CDIV_W-1:0]    core_divide_select_out,
	output var  logic [cdp_pkg::LOCK_W-1:0]    lock_wait_count_out,
	output var  logic                          locking_out,
	output var  logic                          boot_start_out
);
	import cdp_pkg::*;

	cdp_ctl_t            s;
	cdp_ctl_t            next_s;
	logic                rst_evt;
	logic                wake;
	logic [VSEL_W-1:0]   vsel_req;
	logic                volt_chg;
	logic                mult_chg;
	logic                hib_write;
	logic                relock;
	logic                core_run;
	logic                sys_run;
	logic [RATIO_W-1:0]  core_ratio;
	logic [RATIO_W-1:0]  sys_ratio;
	cdp_mode_t           resume;

	always_comb begin
		next_s = s;
		rst_evt = !s.rst_sync[1];
		wake = s.wake_sync[1];
		next_s.rst_sync = {s.rst_sync[0], reset_event_b_in};
		next_s.wake_sync = {s.wake_sync[0], wakeup_in};
		next_s.boot = 1'b0;
		resume = bypass_in ? CDP_ACTIVE : CDP_FULL_ON;
		// Out-of-range voltage requests clamp to the top step
		vsel_req = (voltage_select_in > VSEL_MAX) ? VSEL_MAX : voltage_select_in; // [R7]
		volt_chg = regulator_write_in && (vsel_req != s.vsel);
		mult_chg = multiplier_write_in && (multiplier_select_in >= MULT_MIN)
			&& (multiplier_select_in <= MULT_MAX)
			&& (multiplier_select_in != s.mult);
		hib_write = regulator_write_in && (regulator_field_a_in == REGULATOR_FIELD_A_OFF);
		relock = volt_chg || ((s.mode == CDP_FULL_ON) && mult_chg)
			|| ((s.mode == CDP_ACTIVE) && !bypass_in);

		if (lock_count_write_in) begin
			next_s.lock_cfg = lock_wait_count_in;
		end
		if (divide_write_in) begin
			next_s.sdiv = system_divide_select_in; // [R9] [R10]
			next_s.cdiv = core_divide_select_in; // [R11]
		end
		if (regulator_write_in) begin
			next_s.regulator_field_a = regulator_field_a_in;
			next_s.vsel = vsel_req; // [R7]
		end
		// Zero and codes above 64x are not legal half-step factors and are ignored
		if (mult_chg) begin
			next_s.mult = multiplier_select_in; // [R8]
		end

		unique case (s.mode)
			CDP_FULL_ON, CDP_ACTIVE: begin
				if (hib_write) begin
					next_s.mode = CDP_HIBERNATE; // [R4]
				end else if (deep_sleep_req_in) begin
					next_s.mode = CDP_DEEP_SLEEP;
				end else if (sleep_req_in) begin
					next_s.mode = CDP_SLEEP;
				end else if (relock) begin
					next_s.mode = CDP_LOCK_WAIT; // [R16]
					next_s.lock_cnt = s.lock_cfg;
				end else if ((s.mode == CDP_FULL_ON) && bypass_in) begin
					next_s.mode = CDP_ACTIVE;
				end
			end
			CDP_LOCK_WAIT: begin
				if (hib_write) begin
					next_s.mode = CDP_HIBERNATE; // [R4]
				end else if (s.lock_cnt == LOCK_ZERO) begin
					next_s.mode = resume; // [R16]
				end else begin
					next_s.lock_cnt = s.lock_cnt - LOCK_ONE; // [R13]
				end
			end
			CDP_SLEEP: begin
				if (hib_write) begin
					next_s.mode = CDP_HIBERNATE; // [R4]
				end else if (wake || rst_evt) begin
					next_s.mode = resume; // [R15]
				end
			end
			CDP_DEEP_SLEEP: begin
				if (rst_evt) begin
					next_s.mode = resume; // [R1] [R3]
				end
			end
			CDP_HIBERNATE: begin
				if (rst_evt) begin
					next_s.mode = CDP_BOOT; // [R6]
					next_s.regulator_field_a = REGULATOR_FIELD_A_RESET;
					next_s.boot = 1'b1;
				end
			end
			CDP_BOOT: begin
				// Regulator settles over the programmed lock interval before clocks run
				next_s.mode = CDP_LOCK_WAIT; // [R6]
				next_s.lock_cnt = s.lock_cfg;
			end
			default: begin
				next_s.mode = CDP_FULL_ON;
			end
		endcase

		next_s.block = (next_s.mode == CDP_DEEP_SLEEP)
			|| (next_s.mode == CDP_HIBERNATE); // [R2]
		next_s.tristate = (next_s.mode == CDP_HIBERNATE); // [R5]
		next_s.reg_on = (next_s.mode != CDP_HIBERNATE) && (next_s.regulator_field_a != REGULATOR_FIELD_A_OFF);
		next_s.mv = next_s.reg_on
			? MV_MIN + MV_W'(next_s.vsel) * MV_STEP : MV_OFF; // [R4] [R7]
		next_s.locking = (next_s.mode == CDP_LOCK_WAIT);
	end

	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			s.mode      <= CDP_FULL_ON;
			s.mult      <= MULT_RESET; // [R8]
			s.vsel      <= VSEL_RESET;
			s.regulator_field_a      <= REGULATOR_FIELD_A_RESET;
			s.lock_cfg  <= LOCK_RESET; // [R12]
			s.lock_cnt  <= LOCK_ZERO;
			s.sdiv      <= SDIV_RESET;
			s.cdiv      <= CDIV_RESET;
			s.mv        <= MV_MIN + MV_W'(VSEL_RESET) * MV_STEP;
			s.boot      <= 1'b0;
			s.block     <= 1'b0;
			s.tristate  <= 1'b0;
			s.reg_on    <= 1'b1;
			s.locking   <= 1'b0;
			s.rst_sync  <= 2'h3;
			s.wake_sync <= 2'h0;
		end else begin
			s <= next_s;
		end
	end

	// Bypass runs both clocks at the input rate regardless of divide fields
	always_comb begin
		core_run = (s.mode == CDP_FULL_ON) || (s.mode == CDP_ACTIVE); // [R1]
		sys_run = core_run || (s.mode == CDP_SLEEP); // [R1]
		core_ratio = (s.mode == CDP_ACTIVE) ? RATIO_ONE : RATIO_ONE << s.cdiv; // [R11]
		sys_ratio = (s.mode == CDP_ACTIVE) ? RATIO_ONE : s.sdiv; // [R9]
	end

	cdp_divider u_core_div (
		.clock_in (clock_in),
		.rst_b_in (rst_b_in),
		.run_in   (core_run),
		.ratio_in (core_ratio),
		.tick_out (core_clock_en_out)
	);

	cdp_divider u_sys_div (
		.clock_in (clock_in),
		.rst_b_in (rst_b_in),
		.run_in   (sys_run),
		.ratio_in (sys_ratio),
		.tick_out (system_clock_en_out)
	);

	assign mode_out                 = s.mode;
	assign async_access_block_out   = s.block;
	assign pin_tristate_out         = s.tristate;
	assign regulator_on_out         = s.reg_on;
	assign core_voltage_mv_out      = s.mv;
	assign multiplier_out           = s.mult;
	assign system_divide_select_out = s.sdiv;
	assign core_divide_select_out   = s.cdiv;
	assign lock_wait_count_out      = s.lock_cfg;
	assign locking_out              = s.locking;
	assign boot_start_out           = s.boot;
endmodule // cdp_clock_power

`default_nettype wire

// file: cdp_clock_power_sva.sv
// Port-level assertions for the clock and power-mode block
`default_nettype none

module cdp_clock_power_sva (
	input wire logic               clock_in,
	input wire logic               rst_b_in,
	input wire logic               bypass_in,
	input wire logic               core_clock_en_out,
	input wire logic               system_clock_en_out,
	input wire cdp_pkg::cdp_mode_t mode_out,
	input wire logic               async_access_block_out,
	input wire logic               pin_tristate_out,
	input wire logic               regulator_on_out,
	input wire logic [10:0]        core_voltage_mv_out,
	input wire logic [7:0]         multiplier_out,
	input wire logic [15:0]        lock_wait_count_out,
	input wire logic               locking_out,
	input wire logic               boot_start_out
);
	import cdp_pkg::*;
	logic [16:0] lock_run;

	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);

	// Length of the current lock wait, held for one cycle after it ends, then cleared
	always_ff @(posedge clock_in) begin
		if (!rst_b_in || !locking_out)
			lock_run <= 17'h00000;
		else
			lock_run <= lock_run + 17'h00001;
	end

	AST_DEEP_CLOCKS: assert property (
		mode_out == CDP_DEEP_SLEEP && $past(mode_out) == CDP_DEEP_SLEEP
		|-> !core_clock_en_out && !system_clock_en_out) else $error("clock in deep sleep");
	AST_DEEP_BLOCK: assert property (
		mode_out == CDP_DEEP_SLEEP |-> async_access_block_out) else $error("no block");
	AST_DEEP_EXIT: assert property (
		$past(mode_out) == CDP_DEEP_SLEEP && mode_out != CDP_DEEP_SLEEP
		|-> mode_out == ($past(bypass_in) ? CDP_ACTIVE : CDP_FULL_ON))
		else $error("bad deep exit");
	AST_HIB_STATE: assert property (
		mode_out == CDP_HIBERNATE |-> pin_tristate_out && !regulator_on_out
		&& core_voltage_mv_out == 11'h000) else $error("hibernate outputs wrong");
	AST_HIB_BOOT: assert property (
		$past(mode_out) == CDP_HIBERNATE && mode_out != CDP_HIBERNATE
		|-> mode_out == CDP_BOOT && boot_start_out && regulator_on_out) else $error("no boot");
	AST_VOLT_STEP: assert property (
		regulator_on_out |-> core_voltage_mv_out inside {[11'h352:11'h514]}
		&& (core_voltage_mv_out - 11'h352) % 11'h032 == 11'h000) else $error("bad voltage");
	AST_RESET_VAL: assert property (
		$rose(rst_b_in) |-> mode_out == CDP_FULL_ON && multiplier_out == 8'h14
		&& lock_wait_count_out == 16'h0200) else $error("bad reset values");
	AST_LOCK_HOLD: assert property (
		locking_out && $past(locking_out) |-> !core_clock_en_out && !system_clock_en_out)
		else $error("clock during lock wait");
	AST_LOCK_LEN: assert property (
		// A hibernate write may cut a lock wait short, so only full waits are measured
		$fell(locking_out) && mode_out != CDP_HIBERNATE
		|-> lock_run == {1'b0, lock_wait_count_out} + 17'h00001)
		else $error("lock wait length wrong");
endmodule // cdp_clock_power_sva

bind cdp_clock_power cdp_clock_power_sva cdp_clock_power_sva_inst (.*);
`default_nettype wire

// file: cdp_clock_power_tb_top.sv
// Self-checking bench for the clock and power-mode block
`default_nettype none

module cdp_clock_power_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import cdp_pkg::*;
	logic clock_in, rst_b_in, reset_event_b_in, wakeup_in, bypass_in, sleep_req_in;
	logic deep_sleep_req_in, multiplier_write_in, divide_write_in, regulator_write_in;
	logic lock_count_write_in, core_clock_en_out, system_clock_en_out, async_access_block_out;
	logic pin_tristate_out, regulator_on_out, locking_out, boot_start_out;
	logic [MULT_W-1:0] multiplier_select_in, multiplier_out;
	logic [SDIV_W-1:0] system_divide_select_in, system_divide_select_out;
	logic [CDIV_W-1:0] core_divide_select_in, core_divide_select_out;
	logic [REGULATOR_FIELD_A_W-1:0] regulator_field_a_in;
	logic [VSEL_W-1:0] voltage_select_in;
	logic [LOCK_W-1:0] lock_wait_count_in, lock_wait_count_out;
	logic [MV_W-1:0]   core_voltage_mv_out;
	cdp_mode_t         mode_out;
	int errors, check_count, n, k;

	cdp_clock_power cdp_clock_power_inst (.*);

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic step(input int c);
		repeat (c) @(posedge clock_in);
		#1;
	endtask

	task automatic leave(input cdp_mode_t m, output int c);
		c = 0;
		while (mode_out === m && c < 2000) begin
			step(1);
			c++;
		end
	endtask

	// Cycles between two enable pulses; syncs to a pulse first since a change may wrap the count
	task automatic period(input bit core, output int p);
		p = 0;
		while ((core ? core_clock_en_out : system_clock_en_out) !== 1'b1 && p < 40) begin
			step(1);
			p++;
		end
		p = 0;
		do begin
			step(1);
			p++;
		end while ((core ? core_clock_en_out : system_clock_en_out) !== 1'b1 && p < 40);
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		clock_in = 1'b0;
		forever #25 clock_in = ~clock_in;
	end

	initial begin
		#2500000;
		errors++;
		give_verdict();
	end

	initial begin
		{rst_b_in, wakeup_in, bypass_in, sleep_req_in, deep_sleep_req_in} = '0;
		{multiplier_write_in, divide_write_in, regulator_write_in, lock_count_write_in} = '0;
		{multiplier_select_in, system_divide_select_in, core_divide_select_in} = '0;
		{regulator_field_a_in, voltage_select_in, lock_wait_count_in} = '0;
		reset_event_b_in = 1'b1;
		void'($urandom(88));
		repeat (8) @(posedge clock_in);
		rst_b_in <= 1'b1;
		step(1);
		chk("mult", 16'h0014, 16'(multiplier_out));
		chk("lock", 16'h0200, lock_wait_count_out);
		for (int c = 0; c < 4; c++) begin
			n = (c == 1) ? 6 : $urandom_range(15, 1);
			@(posedge clock_in) begin
				divide_write_in <= 1'b1;
				system_divide_select_in <= 4'(n);
				core_divide_select_in <= 2'(c);
			end
			@(posedge clock_in) divide_write_in <= 1'b0;
			#1 chk("mode", 16'(CDP_FULL_ON), 16'(mode_out));
			period(1'b1, k);
			chk("core_clock", 16'(1 << c), 16'(k));
			period(1'b0, k);
			chk("sclk", 16'(n), 16'(k));
			chk("sdiv", 16'(n), 16'(system_divide_select_out));
			chk("cdiv", 16'(c), 16'(core_divide_select_out));
		end
		@(posedge clock_in) begin
			lock_count_write_in <= 1'b1;
			lock_wait_count_in <= 16'h0320;
		end
		@(posedge clock_in) lock_count_write_in <= 1'b0;
		n = $urandom_range(128, 21);
		@(posedge clock_in) begin
			multiplier_write_in <= 1'b1;
			multiplier_select_in <= 8'(n);
		end
		@(posedge clock_in) multiplier_write_in <= 1'b0;
		#1 chk("mult", 16'(n), 16'(multiplier_out));
		chk("mode", 16'(CDP_LOCK_WAIT), 16'(mode_out));
		chk("locking", 16'h0001, 16'(locking_out));
		leave(CDP_LOCK_WAIT, k);
		chk("lockrun", 16'h0321, 16'(k));
		n = $urandom_range(9, 0);
		@(posedge clock_in) begin
			regulator_write_in <= 1'b1;
			regulator_field_a_in <= 2'h1;
			voltage_select_in <= 4'(n);
		end
		@(posedge clock_in) regulator_write_in <= 1'b0;
		#1 chk("mv", 16'(850 + 50 * n), 16'(core_voltage_mv_out));
		leave(CDP_LOCK_WAIT, k);
		for (int b = 0; b < 2; b++) begin
			@(posedge clock_in) begin
				bypass_in <= 1'(b);
				sleep_req_in <= 1'b1;
			end
			@(posedge clock_in) sleep_req_in <= 1'b0;
			#1 chk("mode", 16'(CDP_SLEEP), 16'(mode_out));
			@(posedge clock_in) wakeup_in <= 1'b1;
			#1 leave(CDP_SLEEP, k);
			chk("mode", 16'(b ? CDP_ACTIVE : CDP_FULL_ON), 16'(mode_out));
			@(posedge clock_in) deep_sleep_req_in <= 1'b1;
			@(posedge clock_in) deep_sleep_req_in <= 1'b0;
			#1 chk("mode", 16'(CDP_DEEP_SLEEP), 16'(mode_out));
			step(6);
			chk("mode", 16'(CDP_DEEP_SLEEP), 16'(mode_out));
			chk("clk", 16'h0000, 16'({core_clock_en_out, system_clock_en_out}));
			chk("block", 16'h0001, 16'(async_access_block_out));
			@(posedge clock_in) begin
				wakeup_in <= 1'b0;
				reset_event_b_in <= 1'b0;
			end
			#1 leave(CDP_DEEP_SLEEP, k);
			chk("mode", 16'(b ? CDP_ACTIVE : CDP_FULL_ON), 16'(mode_out));
			chk("block", 16'h0000, 16'(async_access_block_out));
			@(posedge clock_in) reset_event_b_in <= 1'b1;
		end
		@(posedge clock_in) bypass_in <= 1'b0;
		step(1);
		leave(CDP_ACTIVE, k);
		leave(CDP_LOCK_WAIT, k);
		@(posedge clock_in) begin
			regulator_write_in <= 1'b1;
			regulator_field_a_in <= 2'h0;
		end
		@(posedge clock_in) regulator_write_in <= 1'b0;
		#1 chk("mode", 16'(CDP_HIBERNATE), 16'(mode_out));
		chk("pins", 16'h0001, 16'(pin_tristate_out));
		chk("regon", 16'h0000, 16'(regulator_on_out));
		chk("mv", 16'h0000, 16'(core_voltage_mv_out));
		step(4);
		@(posedge clock_in) reset_event_b_in <= 1'b0;
		#1 leave(CDP_HIBERNATE, k);
		chk("mode", 16'(CDP_BOOT), 16'(mode_out));
		chk("boot", 16'h0001, 16'(boot_start_out));
		@(posedge clock_in) reset_event_b_in <= 1'b1;
		#1 leave(CDP_LOCK_WAIT, k);
		chk("mode", 16'(CDP_FULL_ON), 16'(mode_out));
		chk("mv", 16'(850 + 50 * n), 16'(core_voltage_mv_out));
		give_verdict();
	end
endmodule // cdp_clock_power_tb_top
`default_nettype wire

// file: cdp_divider.sv
// Control package for the clock and power-mode block, and its enable-pulse divider
`default_nettype none

package cdp_pkg;
	localparam int unsigned MULT_W   = 8;
	localparam int unsigned VSEL_W   = 4;
	localparam int unsigned MV_W     = 11;
	localparam int unsigned LOCK_W   = 16;
	localparam int unsigned SDIV_W   = 4;
	localparam int unsigned CDIV_W   = 2;
	localparam int unsigned REGULATOR_FIELD_A_W   = 2;
	localparam int unsigned RATIO_W  = 4;

	// Multiplier is held in half steps: 1 is 0.5x, 128 is 64x
	localparam logic [MULT_W-1:0]  MULT_MIN    = 8'h01;
	localparam logic [MULT_W-1:0]  MULT_MAX    = 8'h80;
	localparam logic [MULT_W-1:0]  MULT_RESET  = 8'h14;
	localparam logic [VSEL_W-1:0]  VSEL_MAX    = 4'h9;
	localparam logic [VSEL_W-1:0]  VSEL_RESET  = 4'h5;
	localparam logic [MV_W-1:0]    MV_MIN      = 11'h352;
	localparam logic [MV_W-1:0]    MV_STEP     = 11'h032;
	localparam logic [MV_W-1:0]    MV_OFF      = 11'h000;
	localparam logic [LOCK_W-1:0]  LOCK_RESET  = 16'h0200;
	localparam logic [LOCK_W-1:0]  LOCK_ZERO   = 16'h0000;
	localparam logic [LOCK_W-1:0]  LOCK_ONE    = 16'h0001;
	localparam logic [REGULATOR_FIELD_A_W-1:0]  REGULATOR_FIELD_A_OFF    = 2'h0;
	localparam logic [REGULATOR_FIELD_A_W-1:0]  REGULATOR_FIELD_A_RESET  = 2'h1;
	localparam logic [SDIV_W-1:0]  SDIV_RESET  = 4'h5;
	localparam logic [CDIV_W-1:0]  CDIV_RESET  = 2'h0;
	localparam logic [RATIO_W-1:0] RATIO_ONE   = 4'h1;
	localparam logic [RATIO_W-1:0] RATIO_ZERO  = 4'h0;

	typedef enum logic [2:0] {
		CDP_FULL_ON    = 3'h0,
		CDP_ACTIVE     = 3'h1,
		CDP_SLEEP      = 3'h2,
		CDP_DEEP_SLEEP = 3'h3,
		CDP_HIBERNATE  = 3'h4,
		CDP_LOCK_WAIT  = 3'h5,
		CDP_BOOT       = 3'h6
	} cdp_mode_t;

	typedef struct packed {
		cdp_mode_t          mode;
		logic [MULT_W-1:0]  mult;
		logic [VSEL_W-1:0]  vsel;
		logic [REGULATOR_FIELD_A_W-1:0]  regulator_field_a;
		logic [LOCK_W-1:0]  lock_cfg;
		logic [LOCK_W-1:0]  lock_cnt;
		logic [SDIV_W-1:0]  sdiv;
		logic [CDIV_W-1:0]  cdiv;
		logic [MV_W-1:0]    mv;
		logic               boot;
		logic               block;
		logic               tristate;
		logic               reg_on;
		logic               locking;
		logic [1:0]         rst_sync;
		logic [1:0]         wake_sync;
	} cdp_ctl_t;

	typedef struct packed {
		logic [RATIO_W-1:0] cnt;
		logic               tick;
	} cdp_div_t;
endpackage

module cdp_divider (
	input  wire logic                      clock_in,
	input  wire logic                      rst_b_in,
	input  wire logic                      run_in,
	input  wire logic [cdp_pkg::RATIO_W-1:0] ratio_in,
	output var  logic                      tick_out
);
	import cdp_pkg::*;

	cdp_div_t                s;
	cdp_div_t                next_s;
	logic [RATIO_W-1:0]      lim;

	always_comb begin
		lim = (ratio_in == RATIO_ZERO) ? RATIO_ZERO : ratio_in - RATIO_ONE;
		next_s = s;
		if (!run_in) begin
			next_s.cnt  = RATIO_ZERO;
			next_s.tick = 1'b0;
		end else if (s.cnt >= lim) begin
			// A ratio lowered mid-count wraps at once, no lock interval needed
			next_s.cnt  = RATIO_ZERO;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt  = s.cnt + RATIO_ONE;
			next_s.tick = 1'b0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!rst_b_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick_out = s.tick;
endmodule // cdp_divider

`default_nettype wire
